// >>> core/evt_timer_pkg.sv
// constants and register map of the 8-bit event counter / pwm timer
package evt_timer_pkg;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFF_CLKSEL = 8'h00;
  localparam logic [7:0] OFF_COMPARE = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  // mode control bit positions
  localparam int unsigned MODE_RUN_BIT = 7;
  localparam int unsigned MODE_PWM_BIT = 6;
  localparam int unsigned MODE_LVS_BIT = 3;
  localparam int unsigned MODE_LVR_BIT = 2;
  localparam int unsigned MODE_TGL_BIT = 1;
  localparam int unsigned MODE_OE_BIT = 0;
  localparam logic [7:0] MODE_RD_MASK = 8'hF3;
  // clock select: values and field width
  localparam logic [7:0] CLKSEL_EVT_FALL = 8'h00;
  localparam logic [7:0] CLKSEL_EVT_RISE = 8'h01;
  localparam logic [2:0] CLKSEL_EVT_MAX = 3'h1;
  localparam int unsigned CLKSEL_FIELD_W = 3;
  localparam logic [7:0] CLKSEL_MASK = 8'h07;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_TOP = 8'hFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  // prescaler width for clock select 2..7 (divide by 4^(sel-1), 2^12 at most)
  localparam int unsigned PRESC_W = 12;
  typedef enum logic [1:0] {
    bus_idle_t_s, bus_write_t_s, bus_read_t_s
  } bus_state_t;
endpackage : evt_timer_pkg

// >>> core/count_tick_gen.sv
// count-clock tick generator: prescaler or synchronous edge detector
`timescale 1ns/1ps
module count_tick_gen
  import evt_timer_pkg::*;
#(
  parameter int unsigned PW = evt_timer_pkg::PRESC_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [2:0] sel,
  input wire logic event_in,
  output logic tick
);
  logic [PW-1:0] presc_reg, presc_next;
  logic event_d_reg, event_d_next;
  logic tick_reg, tick_next;
  logic [PW-1:0] mask;

  always_comb begin
    mask = '0;
    presc_next = run ? presc_reg + 1'b1 : '0;
    event_d_next = event_in;
    tick_next = 1'b0;
    if (sel <= CLKSEL_EVT_MAX) begin
      // edge chosen by select value; pin taken as synchronous
      if (sel[0])
        tick_next = run & event_in & ~event_d_reg;
      else
        tick_next = run & ~event_in & event_d_reg;
    end else begin
      // prescaled clock; the count restarts from zero at run, so the first
      // tick comes one full count period after run
      mask = PW'((1 << (2 * (sel - 3'h1))) - 1);
      tick_next = run & ((presc_reg & mask) == mask);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_reg <= '0;
      event_d_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      presc_reg <= presc_next;
      event_d_reg <= event_d_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule : count_tick_gen

// >>> core/ahb_reg_port.sv
// ahb-lite slave front end: captures one address phase, zero wait states
`timescale 1ns/1ps
module ahb_reg_port
  import evt_timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [evt_timer_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] reg_off
);
  logic wr_reg, wr_next;
  logic rd_reg, rd_next;
  logic [7:0] off_reg, off_next;
  logic take;

  always_comb begin
    take = hsel & hready & (htrans == HTRANS_NONSEQ);
    wr_next = take & hwrite;
    rd_next = take & ~hwrite;
    off_next = take ? haddr[7:0] : off_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      off_reg <= RESET_BYTE;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      off_reg <= off_next;
    end
  end

  assign wr_en = wr_reg;
  assign rd_en = rd_reg;
  assign reg_off = off_reg;
endmodule : ahb_reg_port

// >>> core/evt_timer.sv
// 8-bit event counter, square-wave and pwm timer with ahb-lite registers
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module evt_timer
  import evt_timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [evt_timer_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [evt_timer_pkg::DATA_W-1:0] hwdata,
  output logic [evt_timer_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic event_input_pin,
  output logic timer_output_pin,
  output logic match_interrupt
);
  import evt_timer_pkg::*;

  logic wr_en, rd_en, tick;
  logic [7:0] reg_off;
  logic [7:0] count_clock_select_reg, count_clock_select_next;
  logic [7:0] compare_value_reg, compare_value_next;
  logic [7:0] compare_pend_reg, compare_pend_next;
  logic pend_reg, pend_next;
  // arm: the pending compare was already waiting at the FFH tick
  logic pend_arm_reg, pend_arm_next;
  logic pend_load;
  logic [7:0] mode_control_reg, mode_control_next;
  logic [7:0] up_counter_reg, up_counter_next;
  logic out_ff_reg, out_ff_next;
  logic pwm_act_reg, pwm_act_next;
  logic pin_reg, pin_next;
  logic irq_reg, irq_next;
  logic [DATA_W-1:0] hrdata_reg, hrdata_next;
  logic count_run_bit, pwm_mode_bit, output_gate_bit;
  logic toggle_or_active_level_bit;
  logic match, overflow;
  logic [7:0] wbyte, rbyte;

  ahb_reg_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .reg_off(reg_off)
  );

  count_tick_gen #(.PW(PRESC_W)) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(count_run_bit),
    .sel(count_clock_select_reg[CLKSEL_FIELD_W-1:0]),
    .event_in(event_input_pin),
    .tick(tick)
  );

  assign count_run_bit = mode_control_reg[MODE_RUN_BIT];
  assign pwm_mode_bit = mode_control_reg[MODE_PWM_BIT];
  assign output_gate_bit = mode_control_reg[MODE_OE_BIT];
  assign toggle_or_active_level_bit = mode_control_reg[MODE_TGL_BIT];
  assign wbyte = hwdata[7:0];

  always_comb begin
    match = tick & (up_counter_reg == compare_value_reg);
    overflow = tick & (up_counter_reg == CNT_TOP);
    pend_load = overflow & pend_reg & pend_arm_reg;
    count_clock_select_next = count_clock_select_reg;
    compare_value_next = compare_value_reg;
    compare_pend_next = compare_pend_reg;
    pend_next = pend_reg;
    pend_arm_next = pend_arm_reg;
    mode_control_next = mode_control_reg;
    up_counter_next = up_counter_reg;
    out_ff_next = out_ff_reg;
    pwm_act_next = pwm_act_reg;
    irq_next = 1'b0;

    // counting
    if (!count_run_bit) begin
      up_counter_next = CNT_ZERO;
      pwm_act_next = 1'b0;
    end else if (pwm_mode_bit) begin
      if (tick) begin
        up_counter_next = up_counter_reg + 8'h01;
      end
      // a write landing after the FFH tick is not armed and waits a lap
      if (tick && (up_counter_reg + 8'h01) == CNT_TOP) begin
        pend_arm_next = pend_reg;
      end
      if (overflow) begin
        if (pend_load) begin
          compare_value_next = compare_pend_reg;
          pend_next = 1'b0;
          pend_arm_next = 1'b0;
        end
        pwm_act_next = (pend_load ? compare_pend_reg : compare_value_reg)
                       != CNT_ZERO;
      end else if (tick && (up_counter_reg + 8'h01) == compare_value_reg) begin
        pwm_act_next = 1'b0;
      end
      irq_next = match;
    end else if (tick) begin
      if (match) begin
        up_counter_next = CNT_ZERO;
        irq_next = 1'b1;
        if (toggle_or_active_level_bit)
          out_ff_next = ~out_ff_reg;
      end else begin
        up_counter_next = up_counter_reg + 8'h01;
      end
    end

    // register writes
    if (wr_en) begin
      unique case (reg_off)
        OFF_CLKSEL: count_clock_select_next = wbyte & CLKSEL_MASK;
        OFF_COMPARE: begin
          if (pwm_mode_bit && count_run_bit) begin
            compare_pend_next = wbyte;
            pend_next = 1'b1;
            pend_arm_next = 1'b0;
          end else begin
            compare_value_next = wbyte;
            compare_pend_next = wbyte;
            pend_next = 1'b0;
            pend_arm_next = 1'b0;
          end
        end
        OFF_MODE: begin
          mode_control_next = wbyte & MODE_RD_MASK;
          // level bits act only outside pwm and not both at once
          if (!wbyte[MODE_PWM_BIT]) begin
            if (wbyte[MODE_LVS_BIT] && !wbyte[MODE_LVR_BIT])
              out_ff_next = 1'b1;
            else if (!wbyte[MODE_LVS_BIT] && wbyte[MODE_LVR_BIT])
              out_ff_next = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // pin: gated, pwm level or toggle flop
    if (!mode_control_next[MODE_OE_BIT])
      pin_next = 1'b0;
    else if (mode_control_next[MODE_PWM_BIT])
      // stopping drops the level in the same edge, not one tick later
      pin_next = (pwm_act_next & mode_control_next[MODE_RUN_BIT])
                 ^ mode_control_next[MODE_TGL_BIT];
    else
      pin_next = out_ff_next;
  end

  // read mux
  always_comb begin
    rbyte = RESET_BYTE;
    unique case (haddr[7:0])
      OFF_CLKSEL: rbyte = count_clock_select_reg;
      OFF_COMPARE: rbyte = pend_reg ? compare_pend_reg
                                    : compare_value_reg;
      OFF_MODE: rbyte = mode_control_reg;
      OFF_COUNT: rbyte = up_counter_reg;
      OFF_STATUS: rbyte = {6'h00, pend_reg, out_ff_reg};
      default: rbyte = RESET_BYTE;
    endcase
    hrdata_next = hrdata_reg;
    if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite)
      hrdata_next = {24'h000000, rbyte};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_clock_select_reg <= RESET_BYTE;
      compare_value_reg <= RESET_BYTE;
      compare_pend_reg <= RESET_BYTE;
      pend_reg <= 1'b0;
      pend_arm_reg <= 1'b0;
      mode_control_reg <= RESET_BYTE;
      up_counter_reg <= CNT_ZERO;
      out_ff_reg <= 1'b0;
      pwm_act_reg <= 1'b0;
      pin_reg <= 1'b0;
      irq_reg <= 1'b0;
      hrdata_reg <= '0;
    end else begin
      count_clock_select_reg <= count_clock_select_next;
      compare_value_reg <= compare_value_next;
      compare_pend_reg <= compare_pend_next;
      pend_reg <= pend_next;
      pend_arm_reg <= pend_arm_next;
      mode_control_reg <= mode_control_next;
      up_counter_reg <= up_counter_next;
      out_ff_reg <= out_ff_next;
      pwm_act_reg <= pwm_act_next;
      pin_reg <= pin_next;
      irq_reg <= irq_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign timer_output_pin = pin_reg;
  assign match_interrupt = irq_reg;
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1; // zero wait states, always ready
  assign hresp = HRESP_OKAY;

  // antecedents skip same-cycle writes where a write may reload the checked state
  a_match_clears: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (count_run_bit && !pwm_mode_bit && match) |=>
      (up_counter_reg == CNT_ZERO) && match_interrupt)
    else $error("match did not clear counter");
  a_stop_clears: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !count_run_bit |=> up_counter_reg == CNT_ZERO)
    else $error("stopped counter not zero");
  a_gate_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!output_gate_bit && !wr_en) |=> !timer_output_pin)
    else $error("output not gated low");
  a_toggle_flop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (count_run_bit && !pwm_mode_bit && toggle_or_active_level_bit
     && match && !wr_en) |=> out_ff_reg != $past(out_ff_reg))
    else $error("flop did not toggle");
  a_pwm_stop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!count_run_bit && pwm_mode_bit && output_gate_bit && !wr_en)
      |=> timer_output_pin == toggle_or_active_level_bit)
    else $error("pwm not inactive when stopped");
  a_pwm_wrap: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (count_run_bit && pwm_mode_bit && overflow && !wr_en)
      |=> up_counter_reg == CNT_ZERO)
    else $error("pwm counter did not wrap");
  a_pend_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_en && reg_off == OFF_COMPARE && pwm_mode_bit && count_run_bit)
      |=> pend_reg && compare_pend_reg == $past(wbyte))
    else $error("pending compare not held");
  a_count_edge: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (count_run_bit && !pwm_mode_bit && tick && !match && !wr_en)
      |=> up_counter_reg == $past(up_counter_reg) + 8'h01)
    else $error("counter missed an edge");
  a_level_high: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_en && reg_off == OFF_MODE && !wbyte[MODE_PWM_BIT]
     && wbyte[MODE_LVS_BIT] && !wbyte[MODE_LVR_BIT]) |=> out_ff_reg)
    else $error("level set did not raise flop");
  a_level_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_en && reg_off == OFF_MODE && !wbyte[MODE_PWM_BIT]
     && !wbyte[MODE_LVS_BIT] && wbyte[MODE_LVR_BIT]) |=> !out_ff_reg)
    else $error("level reset did not clear flop");
  a_level_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
     && haddr[7:0] == OFF_MODE)
      |=> hrdata[MODE_LVS_BIT] == 1'b0 && hrdata[MODE_LVR_BIT] == 1'b0)
    else $error("level bits read back nonzero");
  a_pwm_rise: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (count_run_bit && pwm_mode_bit && output_gate_bit && overflow
     && !pend_load && compare_value_reg != CNT_ZERO && !wr_en)
      |=> timer_output_pin != toggle_or_active_level_bit)
    else $error("pwm not active after overflow");
  a_pwm_width: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (count_run_bit && pwm_mode_bit && up_counter_reg >= compare_value_reg)
      |-> !pwm_act_reg)
    else $error("pwm active past compare");
  a_pend_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (count_run_bit && pwm_mode_bit && pend_load && !wr_en)
      |=> !pend_reg && compare_value_reg == $past(compare_pend_reg))
    else $error("pending compare not loaded at overflow");
  a_irq_pulse: assert property (
    @(posedge hclk) disable iff (!hresetn)
    match_interrupt |=> !match_interrupt)
    else $error("interrupt held longer than a cycle");
endmodule : evt_timer

// >>> verification/pin_partner.sv
// far-side model: event pulse source and load on the timer pin
`timescale 1ns/1ps
module pin_partner (
  input wire logic hclk,
  input wire logic timer_output_pin,
  output logic event_input_pin,
  output logic [15:0] last_period,
  output logic [15:0] last_high
);
  logic [15:0] since_rise;
  logic prev_out;
  initial begin
    event_input_pin = 1'b0;
    since_rise = 16'h0;
    prev_out = 1'b0;
    last_period = 16'h0;
    last_high = 16'h0;
  end
  // load side: period and high time of the output in hclk cycles
  always @(posedge hclk) begin
    prev_out <= timer_output_pin;
    since_rise <= since_rise + 16'h1;
    if (timer_output_pin === 1'b1 && prev_out === 1'b0) begin
      last_period <= since_rise + 16'h1;
      since_rise <= 16'h0;
    end
    if (timer_output_pin === 1'b0 && prev_out === 1'b1) begin
      last_high <= since_rise + 16'h1;
    end
  end
  // level held six cycles: the block needs two to count an edge
  task drive_level(input logic v);
    @(posedge hclk);
    event_input_pin <= v;
    repeat (6) @(posedge hclk);
  endtask : drive_level
endmodule : pin_partner

// >>> verification/evt_timer_tb.sv
// self-checking bench for the event counter / pwm timer
`timescale 1ns/1ps
module evt_timer_tb;
  import evt_timer_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic event_input_pin, timer_output_pin, match_interrupt;
  logic [15:0] last_period, last_high;
  int err_count, checks_done, irq_n, irq0, i;

  evt_timer evt_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hsize(hsize), .hwrite(hwrite),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .event_input_pin(event_input_pin),
    .timer_output_pin(timer_output_pin),
    .match_interrupt(match_interrupt));
  pin_partner pin_partner_i (.hclk(hclk),
    .timer_output_pin(timer_output_pin),
    .event_input_pin(event_input_pin), .last_period(last_period),
    .last_high(last_high));

  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    if (match_interrupt === 1'b1) irq_n <= irq_n + 1;
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task chkpin(input logic v);
    chk({31'h0, timer_output_pin}, {31'h0, v});
  endtask : chkpin

  // bounded: a stalled slave ends the run instead of hanging
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: bus stalled", $time);
      wrap_up();
    end
  endtask : wait_ready

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rdat = hrdata;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h0, d});
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rdat, exp);
  endtask : rd

  // output is registered on the same edge as the mode register: let both land
  task settle;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
  endtask : settle

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = HSIZE_WORD;
    hwrite = 1'b0;
    hwdata = 32'h0;
    err_count = 0;
    checks_done = 0;
    irq_n = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFF_CLKSEL, 32'h0);
    rd(OFF_COMPARE, 32'h0);
    rd(OFF_MODE, 32'h0);
    rd(OFF_COUNT, 32'h0);
    rd(8'h14, 32'h0);
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    // falling then rising edge select: one rise and one fall each
    for (i = 0; i < 2; i++) begin
      wr(OFF_MODE, 8'h00);
      wr(OFF_CLKSEL, (i == 1) ? CLKSEL_EVT_RISE : CLKSEL_EVT_FALL);
      wr(OFF_COMPARE, 8'hFF);
      rd(OFF_COUNT, 32'h0);
      wr(OFF_MODE, 8'h80);
      pin_partner_i.drive_level(1'b1);
      rd(OFF_COUNT, (i == 1) ? 32'h1 : 32'h0);
      pin_partner_i.drive_level(1'b0);
      rd(OFF_COUNT, 32'h1);
    end
    // compare 2: three events per interrupt, counter back at zero
    wr(OFF_MODE, 8'h00);
    wr(OFF_COMPARE, 8'h02);
    wr(OFF_MODE, 8'h80);
    irq0 = irq_n;
    repeat (6) begin
      pin_partner_i.drive_level(1'b1);
      pin_partner_i.drive_level(1'b0);
    end
    chk(32'(irq_n - irq0), 32'h2);
    rd(OFF_COUNT, 32'h0);
    // square wave, count clock every 4 hclk, compare 3
    wr(OFF_MODE, 8'h00);
    wr(OFF_CLKSEL, 8'h02);
    wr(OFF_COMPARE, 8'h03);
    wr(OFF_MODE, 8'h02);
    wr(OFF_MODE, 8'h03);
    wr(OFF_MODE, 8'h0B);
    rd(OFF_MODE, 32'h03);
    chkpin(1'b1);
    wr(OFF_MODE, 8'h83);
    repeat (200) @(posedge hclk);
    chk({16'h0, last_period}, 32'd32);
    chk({16'h0, last_high}, 32'd16);
    wr(OFF_MODE, 8'h03);
    wr(OFF_MODE, 8'h07);
    settle();
    chkpin(1'b0);
    wr(OFF_MODE, 8'h02);
    wr(OFF_MODE, 8'h0A);
    settle();
    chkpin(1'b0);
    rd(OFF_STATUS, 32'h1);
    // pwm, active high then active low
    wr(OFF_MODE, 8'h00);
    wr(OFF_COMPARE, 8'h40);
    wr(OFF_MODE, 8'h41);
    wr(OFF_MODE, 8'hC1);
    settle();
    chkpin(1'b0);
    repeat (2600) @(posedge hclk);
    chk({16'h0, last_period}, 32'd1024);
    chk({16'h0, last_high}, 32'd256);
    wr(OFF_MODE, 8'h41);
    wr(OFF_MODE, 8'h43);
    wr(OFF_MODE, 8'hC3);
    repeat (2600) @(posedge hclk);
    chk({16'h0, last_high}, 32'd768);
    wr(OFF_COMPARE, 8'h20);
    rd(OFF_COMPARE, 32'h20);
    repeat (3200) @(posedge hclk);
    chk({16'h0, last_high}, 32'd896);
    chk({16'h0, last_period}, 32'd1024);
    wr(OFF_MODE, 8'h43);
    settle();
    chkpin(1'b1);
    // reset with the counter stopped: registers and pin back to their idle values
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFF_MODE, 32'h0);
    rd(OFF_COUNT, 32'h0);
    chkpin(1'b0);
    wrap_up();
  end
endmodule : evt_timer_tb
